// File: design/pwt_defs.svh
// Purpose: Constants of the periodic wakeup timer and its trim registers.
// Assumes: 8-bit register port, 40 MHz sys_clk, one slow RC tick input.
// Notes: Offsets are byte addresses on the plain register port.
//
// Behaviour
// RL1: On reset release the slow clock trim loads from non-volatile memory.
// RL2: Slow clock trim is six signed bits; top lengthens, lower bits shorten.
// RL3: Rate writes only land while feature enable is clear.
// RL4: Time-out length is a 16-bit rate from high and low bytes.
// RL5: Slow clock source gives four times rate plus one slow periods.
// RL6: Bus clock source gives two times rate plus one bus periods.
// RL7: Slow source first time-out waits two to three slow cycles for gate.
// RL8: Factory test register reads anytime, writes only in special mode.
// RL9: On reset release the temperature trim loads from non-volatile memory.
// RL10: Temperature offset enable gates the binary weighted 4-bit trim.
// RL11: Feature enable starts the periodic timer; clearing it stops time-outs.
// RL12: Each period sets the flag; write one clears; interrupt when enabled.
// RL13: Clock select writable only while disabled, not by the enabling write.
// RL14: After each time-out the counter reloads and repeats by itself.
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH

////////////////////////////////////////////////////////////////////////////
`define PWT_ADDR_W 8
`define PWT_DATA_W 8
`define PWT_OFS_CTRL 8'h12
`define PWT_OFS_SLOW_TRIM 8'h13
`define PWT_OFS_RATE_HIGH 8'h14
`define PWT_OFS_RATE_LOW 8'h15
`define PWT_OFS_TEST3 8'h16
`define PWT_OFS_TEMP_TRIM 8'h17

////////////////////////////////////////////////////////////////////////////
`define PWT_CTRL_CLK_SEL 7
`define PWT_CTRL_FEAT_EN 2
`define PWT_CTRL_IRQ_EN 1
`define PWT_CTRL_FLAG 0
`define PWT_SLOW_TRIM_MSB 5
`define PWT_TEMP_EN 7
`define PWT_TEMP_MSB 3

////////////////////////////////////////////////////////////////////////////
`define PWT_RST_BYTE 8'h00
`define PWT_RST_RATE 16'h0000
`define PWT_CNT_W 18
`define PWT_GATE_TICKS 2'h1

`endif

// File: design/pwt_pkg.sv
// Purpose: Types shared by the periodic wakeup timer files.
// Assumes: Constants live in pwt_defs.svh.
// Notes: States of the counter clock gate.
package pwt_pkg;
  typedef enum logic [1:0] {
    PWT_IDLE = 2'b00,
    PWT_GATE = 2'b01,
    PWT_RUN  = 2'b10
  } pwt_state_t;
  typedef logic [17:0] pwt_count_t;
endpackage

// File: design/pwt_period_counter.sv
// Purpose: Down counter that marks each elapsed time-out period.
// Assumes: tick is a one-cycle enable from the selected source.
// Notes: Reloads itself so periods repeat without software.
`include "pwt_defs.svh"
module pwt_period_counter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic tick,
  input wire pwt_pkg::pwt_count_t load_value,
  // Event
  output logic timeout
);
  import pwt_pkg::*;

  pwt_count_t count;

  ////////////////////////////////////////////////////////////////////////////
  // Holding the load while stopped makes the first period exact.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (clk_en) begin
      if (!run) begin
        count <= load_value;
      end else if (tick) begin
        if (count == '0) begin
          count <= load_value; // [RL14]
        end else begin
          count <= count - 18'h00001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      timeout <= 1'b0;
    end else if (clk_en) begin
      timeout <= run && tick && (count == '0);
    end
  end
endmodule

// File: design/pwt_timer.sv
// Purpose: Periodic wakeup timer with slow clock and temperature trims.
// Assumes: slow_tick pulses once per slow RC clock cycle, synchronous.
// Notes: Trim values load from non-volatile inputs once after reset.
//
// The implementer's own choice: the strobed register port.
`include "pwt_defs.svh"
module pwt_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Slow clock and mode
  input wire logic slow_tick,
  input wire logic special_mode,
  // Non-volatile trim values
  input wire logic [7:0] nvm_slow_trim,
  input wire logic [7:0] nvm_temp_trim,
  // Outputs to the analog side
  output logic signed [5:0] slow_clock_trim_bits,
  output logic [3:0] temperature_offset,
  output logic [7:0] factory_test_three,
  // Interrupt
  output logic irq
);
  import pwt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic periodic_clock_select;
  logic periodic_feature_enable;
  logic periodic_irq_enable;
  logic periodic_timeout_flag;
  logic [15:0] periodic_rate_value;
  logic [7:0] slow_clock_trim;
  logic [7:0] temperature_sense_trim;
  logic trims_loaded;
  logic [1:0] gate_count;
  pwt_state_t state;
  pwt_state_t next_state;
  pwt_count_t load_value;
  logic count_tick;
  logic timeout;
  logic wr_ctrl;
  logic wr_slow;
  logic wr_rate_h;
  logic wr_rate_l;
  logic wr_test;
  logic wr_temp;

  assign wr_ctrl = reg_wr && (reg_addr == `PWT_OFS_CTRL);
  assign wr_slow = reg_wr && (reg_addr == `PWT_OFS_SLOW_TRIM);
  assign wr_rate_h = reg_wr && (reg_addr == `PWT_OFS_RATE_HIGH);
  assign wr_rate_l = reg_wr && (reg_addr == `PWT_OFS_RATE_LOW);
  assign wr_test = reg_wr && (reg_addr == `PWT_OFS_TEST3);
  assign wr_temp = reg_wr && (reg_addr == `PWT_OFS_TEMP_TRIM);

  ////////////////////////////////////////////////////////////////////////////
  // Control bits.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_feature_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      periodic_feature_enable <= reg_wdata[`PWT_CTRL_FEAT_EN]; // [RL11]
      periodic_irq_enable <= reg_wdata[`PWT_CTRL_IRQ_EN];
    end
  end

  // The old enable and the written enable bit are both looked at, so the enabling write cannot move it.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_clock_select <= 1'b0;
    end else if (clk_en && wr_ctrl && !periodic_feature_enable &&
                 !reg_wdata[`PWT_CTRL_FEAT_EN]) begin
      periodic_clock_select <= reg_wdata[`PWT_CTRL_CLK_SEL]; // [RL13]
    end
  end

  // A time-out in the clearing cycle keeps the flag set.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_timeout_flag <= 1'b0;
    end else if (clk_en) begin
      if (timeout) begin
        periodic_timeout_flag <= 1'b1; // [RL12]
      end else if (wr_ctrl && reg_wdata[`PWT_CTRL_FLAG]) begin
        periodic_timeout_flag <= 1'b0; // [RL12]
      end
    end
  end

  assign irq = periodic_timeout_flag && periodic_irq_enable; // [RL12]

  ////////////////////////////////////////////////////////////////////////////
  // Rate bytes.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      periodic_rate_value <= `PWT_RST_RATE;
    end else if (clk_en && !periodic_feature_enable) begin
      if (wr_rate_h) begin
        periodic_rate_value[15:8] <= reg_wdata; // [RL3] [RL4]
      end
      if (wr_rate_l) begin
        periodic_rate_value[7:0] <= reg_wdata; // [RL3] [RL4]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trims load on the first enabled cycle after reset release, since an
  // asynchronous reset may only take constants.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trims_loaded <= 1'b0;
    end else if (clk_en) begin
      trims_loaded <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      slow_clock_trim <= `PWT_RST_BYTE;
    end else if (clk_en) begin
      if (!trims_loaded) begin
        slow_clock_trim <= nvm_slow_trim; // [RL1]
      end else if (wr_slow) begin
        slow_clock_trim <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      temperature_sense_trim <= `PWT_RST_BYTE;
    end else if (clk_en) begin
      if (!trims_loaded) begin
        temperature_sense_trim <= nvm_temp_trim; // [RL9]
      end else if (wr_temp) begin
        temperature_sense_trim <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      factory_test_three <= `PWT_RST_BYTE;
    end else if (clk_en && wr_test && special_mode) begin
      factory_test_three <= reg_wdata; // [RL8]
    end
  end

  // Signed code for the oscillator: bit 5 lengthens, lower bits shorten.
  assign slow_clock_trim_bits =
    $signed(slow_clock_trim[`PWT_SLOW_TRIM_MSB:0]); // [RL2]

  // Binary weighted offset code, ignored while the enable is clear.
  assign temperature_offset = temperature_sense_trim[`PWT_TEMP_EN] ?
    temperature_sense_trim[`PWT_TEMP_MSB:0] : 4'h0; // [RL10]

  ////////////////////////////////////////////////////////////////////////////
  // Clock gate: the slow source needs two slow ticks before counting.
  always_comb begin
    next_state = state;
    unique case (state)
      PWT_IDLE: begin
        if (periodic_feature_enable) begin
          next_state = periodic_clock_select ? PWT_RUN : PWT_GATE; // [RL11]
        end
      end
      PWT_GATE: begin
        if (!periodic_feature_enable) begin
          next_state = PWT_IDLE;
        end else if (slow_tick && gate_count == `PWT_GATE_TICKS) begin
          next_state = PWT_RUN; // [RL7]
        end
      end
      PWT_RUN: begin
        if (!periodic_feature_enable) begin
          next_state = PWT_IDLE; // [RL11]
        end
      end
      default: begin
        next_state = PWT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= PWT_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gate_count <= 2'h0;
    end else if (clk_en) begin
      if (state != PWT_GATE) begin
        gate_count <= 2'h0;
      end else if (slow_tick) begin
        gate_count <= gate_count + 2'h1; // [RL7]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter load is one less than the number of source ticks per period.
  assign load_value = periodic_clock_select ?
    {1'b0, periodic_rate_value, 1'b1} : // [RL6]
    {periodic_rate_value, 2'b11}; // [RL5]
  assign count_tick = periodic_clock_select ? 1'b1 : slow_tick;

  pwt_period_counter u_counter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .run(state == PWT_RUN),
    .tick(count_tick),
    .load_value(load_value),
    .timeout(timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe; unmapped reads 0.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `PWT_RST_BYTE;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          `PWT_OFS_CTRL: begin
            reg_rdata <= {periodic_clock_select, 4'h0,
                          periodic_feature_enable, periodic_irq_enable,
                          periodic_timeout_flag};
          end
          `PWT_OFS_SLOW_TRIM: reg_rdata <= {2'b00, slow_clock_trim[5:0]};
          `PWT_OFS_RATE_HIGH: reg_rdata <= periodic_rate_value[15:8];
          `PWT_OFS_RATE_LOW: reg_rdata <= periodic_rate_value[7:0];
          `PWT_OFS_TEST3: reg_rdata <= factory_test_three; // [RL8]
          `PWT_OFS_TEMP_TRIM: begin
            reg_rdata <= {temperature_sense_trim[7], 3'h0,
                          temperature_sense_trim[3:0]};
          end
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// File: tb/pwt_timer_properties.sv
// Purpose: Port-level properties of the periodic wakeup timer.
// Assumes: Bound to pwt_timer; one clock domain.
// Notes: Trim loads are judged at the first edge after reset release.
module pwt_timer_check (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Trims, mode and interrupt
  input wire logic special_mode,
  input wire logic [7:0] nvm_slow_trim,
  input wire logic [7:0] nvm_temp_trim,
  input wire logic signed [5:0] slow_clock_trim_bits,
  input wire logic [3:0] temperature_offset,
  input wire logic [7:0] factory_test_three,
  input wire logic irq
);
  import pwt_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic w12;
  logic w13;
  logic w16;
  logic w17;
  assign w12 = clk_en && reg_wr && reg_addr == 8'h12;
  assign w13 = clk_en && reg_wr && reg_addr == 8'h13;
  assign w16 = clk_en && reg_wr && reg_addr == 8'h16;
  assign w17 = clk_en && reg_wr && reg_addr == 8'h17;
  ////////////////////////////////////////////////////////////////////////////
  load_slow_a: assert property ($rose(nrst) && clk_en |=>
    slow_clock_trim_bits == $past(nvm_slow_trim[5:0]))
    else $error("slow trim not loaded after reset");
  load_temp_a: assert property ($rose(nrst) && clk_en |=>
    temperature_offset == ($past(nvm_temp_trim[7]) ?
    $past(nvm_temp_trim[3:0]) : 4'h0))
    else $error("temperature trim not loaded after reset");
  trim_wr_a: assert property (w13 |=>
    slow_clock_trim_bits == $past(reg_wdata[5:0]))
    else $error("slow trim write lost");
  temp_off_a: assert property (w17 && !reg_wdata[7] |=>
    temperature_offset == 4'h0) else $error("offset not gated off");
  temp_on_a: assert property (w17 && reg_wdata[7] |=>
    temperature_offset == $past(reg_wdata[3:0]))
    else $error("offset not taken from trim");
  test_lock_a: assert property (w16 && !special_mode |=>
    $stable(factory_test_three)) else $error("test reg written");
  test_wr_a: assert property (w16 && special_mode |=>
    factory_test_three == $past(reg_wdata))
    else $error("test reg write lost");
  irq_off_a: assert property (w12 && !reg_wdata[1] |=> !irq)
    else $error("irq high while masked");
endmodule
bind pwt_timer pwt_timer_check pwt_timer_check_inst (
  .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .special_mode(special_mode),
  .nvm_slow_trim(nvm_slow_trim), .nvm_temp_trim(nvm_temp_trim),
  .slow_clock_trim_bits(slow_clock_trim_bits), .irq(irq),
  .temperature_offset(temperature_offset),
  .factory_test_three(factory_test_three));

// File: tb/pwt_timer_tb_top.sv
// Purpose: Self-checking bench of the periodic wakeup timer.
// Assumes: 40 MHz sys_clk; clk_en held high for the whole run.
// Notes: A slow tick every fourth cycle keeps slow periods short.
module pwt_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pwt_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, special_mode = 1'b0;
  logic slow_tick = 1'b0, irq;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ftt, rd_val;
  logic [7:0] nvm_slow_trim = 8'heb, nvm_temp_trim = 8'h8c;
  logic signed [5:0] sct;
  logic [3:0] toff;
  int n_errors = 0, n_checks = 0, cyc = 0, r1, i;
  logic [7:0] rows [8][3] = '{'{8'h13, 8'hff, 8'h3f},
    '{8'h13, 8'h20, 8'h20}, '{8'h14, 8'ha5, 8'ha5}, '{8'h15, 8'h5a, 8'h5a},
    '{8'h17, 8'h85, 8'h85}, '{8'h16, 8'h77, 8'h00}, '{8'h12, 8'h82, 8'h82},
    '{8'h20, 8'hff, 8'h00}};
  ////////////////////////////////////////////////////////////////////////////
  pwt_timer pwt_timer_inst (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slow_tick(slow_tick),
    .special_mode(special_mode), .nvm_slow_trim(nvm_slow_trim),
    .nvm_temp_trim(nvm_temp_trim), .slow_clock_trim_bits(sct),
    .temperature_offset(toff), .factory_test_three(ftt), .irq(irq));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    slow_tick <= (cyc % 4 == 3);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] exp, got, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Every call spans one edge, so strobes never change twice in a step.
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wait_irq;
    for (i = 0; i < 300 && irq !== 1'b1; i++) bus(1'b0, 1'b0, 8'h00, 8'h00);
    chk(8'h01, {7'h0, irq}, "irq");
  endtask
  // The rate write in mid-period must be dropped while running.
  task automatic period(input logic [7:0] ctl, exp, input string what);
    wait_irq;
    r1 = cyc;
    wr(8'h15, 8'h00);
    wr(8'h12, ctl);
    wait_irq;
    chk(exp, 8'(cyc - r1), what);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(8'h13);
    chk(8'h2b, rd_val, "slow trim");
    chk(8'h2b, {2'b00, sct}, "trim bits");
    rd(8'h17);
    chk(8'h8c, rd_val, "temp trim");
    chk(8'h0c, {4'h0, toff}, "temp offset");
    for (int k = 0; k < 8; k++) begin
      wr(rows[k][0], rows[k][1]);
      rd(rows[k][0]);
      chk(rows[k][2], rd_val, "readback");
    end
    wr(8'h17, 8'h05);
    chk(8'h00, {4'h0, toff}, "offset gated");
    special_mode <= 1'b1;
    wr(8'h16, 8'h77);
    chk(8'h77, ftt, "test reg");
    special_mode <= 1'b0;
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h02);
    wr(8'h12, 8'h86);
    period(8'h87, 8'h06, "bus period");
    rd(8'h15);
    chk(8'h02, rd_val, "rate kept");
    wr(8'h12, 8'h06);
    rd(8'h12);
    chk(8'h01, {7'h0, rd_val[7]}, "select kept");
    wr(8'h12, 8'h03);
    // A time-out already in flight may set the flag once more; clear again.
    repeat (4) bus(1'b0, 1'b0, 8'h00, 8'h00);
    wr(8'h12, 8'h03);
    repeat (20) bus(1'b0, 1'b0, 8'h00, 8'h00);
    chk(8'h00, {7'h0, irq}, "stopped");
    wr(8'h12, 8'h02);
    wr(8'h15, 8'h01);
    wr(8'h12, 8'h86);
    period(8'h07, 8'd32, "slow period");
    wr(8'h12, 8'h01);
    // A second reset in mid-run must fetch the trim again.
    nrst <= 1'b0;
    nvm_slow_trim <= 8'h15;
    repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
    nrst <= 1'b1;
    repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
    rd(8'h13);
    chk(8'h15, rd_val, "slow trim reload");
    chk(8'h00, {7'h0, irq}, "irq after reset");
    test_done;
  end
endmodule
